// [hdl/fsp_pkg.sv]
package fsp_pkg;

   // -----------------------------------------------------------------
   // Register map of the controller (APB, byte addresses)
   // -----------------------------------------------------------------
   localparam logic [11:0] FSP_CTRL_OFF = 12'h000;
   localparam logic [11:0] FSP_ADDR_OFF = 12'h004;
   localparam logic [11:0] FSP_STAT_OFF = 12'h008;
   localparam logic [11:0] FSP_DATA_OFF = 12'h00C;

   // Control register fields.
   localparam int FSP_CTRL_POLL_BIT = 0;
   localparam int FSP_CTRL_WIN_BIT = 1;
   localparam int FSP_CTRL_ABORT_BIT = 2;
   localparam int FSP_CTRL_ERASE_BIT = 3;

   // Status register fields.
   localparam int FSP_ST_BUSY_BIT = 0;
   localparam int FSP_ST_DONE_BIT = 1;
   localparam int FSP_ST_FAIL_BIT = 2;
   localparam int FSP_ST_WIN_BIT = 3;
   localparam int FSP_ST_SUSP_BIT = 4;
   localparam int FSP_ST_RDY_BIT = 5;

   // Status bit positions in the device's low data byte.
   localparam int FSP_DQ_ERASE_TGL = 2;
   localparam int FSP_DQ_WINDOW = 3;
   localparam int FSP_DQ_LIMIT = 5;
   localparam int FSP_DQ_ACT_TGL = 6;
   localparam int FSP_DQ_POLL = 7;

   // Reset command data word.
   localparam logic [15:0] FSP_RESET_CMD = 16'h00F0;

   // -----------------------------------------------------------------
   // Flash bus timing at 40 MHz (25 ns period)
   // -----------------------------------------------------------------
   localparam int FSP_CLK_NS = 25;
   localparam int FSP_TRC_NS = 70;
   localparam int FSP_TOE_NS = 30;
   localparam int FSP_TACC_NS = 70;
   localparam int FSP_TOEH_NS = 10;
   // Read strobe is held until the slowest access time has passed (min, round up).
   localparam int FSP_RD_CYC = (FSP_TACC_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
   // Idle gap between cycles covers output hold and cycle time.
   localparam int FSP_GAP_CYC = (FSP_TRC_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
   localparam int FSP_WR_CYC = FSP_GAP_CYC;

   // Sequencer states.
   typedef enum logic [3:0] {
      FSP_IDLE, FSP_RD1, FSP_RD2, FSP_CHK, FSP_RD3, FSP_CHK3,
      FSP_RDWIN, FSP_WRRST, FSP_GAP
   } fsp_state_t;

   // Flash pin bundle driven by the controller.
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [17:0] addr;
      logic [15:0] dout;
      logic doe;
   } fsp_flash_out_t;

   // APB request bundle.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fsp_apb_req_t;

endpackage

// [hdl/fsp_poller.sv]
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module fsp_poller
   import fsp_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash pins
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [17:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in,
   input wire logic ready_busy_output
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   fsp_state_t state_ff;
   fsp_state_t ret_ff;
   fsp_flash_out_t pins_ff;
   logic [17:0] addr_ff;
   logic erase_ff;
   logic busy_ff, done_ff, fail_ff, win_ff, susp_ff;
   logic [7:0] first_ff;
   logic [7:0] last_ff;
   logic [3:0] cnt_ff;
   logic [2:0] rb_sync_ff;
   logic rdy_ff;
   logic [7:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
   logic start_poll, start_win, abort, wr_en;

   // ---------------------------------------------------------------
   // APB slave: zero wait states, unmapped reads zero with error
   // ---------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign start_poll = wr_en && (paddr == FSP_CTRL_OFF) && pwdata[FSP_CTRL_POLL_BIT];
   assign start_win = wr_en && (paddr == FSP_CTRL_OFF) && pwdata[FSP_CTRL_WIN_BIT];
   assign abort = wr_en && (paddr == FSP_CTRL_OFF) && pwdata[FSP_CTRL_ABORT_BIT];

   always_comb
   begin
      pslverr = 1'b0;
      prdata = 32'h00000000;
      if (paddr == FSP_CTRL_OFF)
      begin
         prdata[FSP_CTRL_ERASE_BIT] = erase_ff;
      end
      else if (paddr == FSP_ADDR_OFF)
      begin
         prdata[17:0] = addr_ff;
      end
      else if (paddr == FSP_STAT_OFF)
      begin
         prdata[FSP_ST_BUSY_BIT] = busy_ff;
         prdata[FSP_ST_DONE_BIT] = done_ff;
         prdata[FSP_ST_FAIL_BIT] = fail_ff;
         prdata[FSP_ST_WIN_BIT] = win_ff;
         prdata[FSP_ST_SUSP_BIT] = susp_ff;
         prdata[FSP_ST_RDY_BIT] = rdy_ff;
      end
      else if (paddr == FSP_DATA_OFF)
      begin
         prdata[15:0] = {last_ff, first_ff};
      end
      else
      begin
         pslverr = psel && penable;
      end
   end

   // Address of the valid polling location and erase kind.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_ff <= 18'h00000;
         erase_ff <= 1'b0;
      end
      else if (wr_en && paddr == FSP_ADDR_OFF && !busy_ff)
      begin
         addr_ff <= pwdata[17:0];
      end
      else if (wr_en && paddr == FSP_CTRL_OFF && !busy_ff)
      begin
         erase_ff <= pwdata[FSP_CTRL_ERASE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchronisers: three stages; ready changes when two agree
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rb_sync_ff <= 3'h7;
         rdy_ff <= 1'b1;
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
         dq_s3_ff <= 8'h00;
      end
      else
      begin
         rb_sync_ff <= {rb_sync_ff[1:0], ready_busy_output};
         if (rb_sync_ff[2] == rb_sync_ff[1])
         begin
            rdy_ff <= rb_sync_ff[1]; // Low means device busy.
         end
         dq_s1_ff <= flash_dq_in[7:0];
         dq_s2_ff <= dq_s1_ff;
         dq_s3_ff <= dq_s2_ff;
      end
   end

   // ---------------------------------------------------------------
   // Polling sequencer
   // ---------------------------------------------------------------
   // Reads are strobed long enough that the sampled byte is settled by the
   // time the third stage holds it; the extra stages cost a few cycles only.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= FSP_IDLE;
         ret_ff <= FSP_IDLE;
         cnt_ff <= 4'h0;
         pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h00000,
                      dout: 16'h0000, doe: 1'b0};
         first_ff <= 8'h00;
         last_ff <= 8'h00;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         win_ff <= 1'b0;
         susp_ff <= 1'b0;
      end
      else if (abort)
      begin
         // Leaving polling discards history; the next start is from scratch.
         state_ff <= FSP_IDLE;
         pins_ff.ce_n <= 1'b1;
         pins_ff.oe_n <= 1'b1;
         pins_ff.we_n <= 1'b1;
         pins_ff.doe <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            FSP_IDLE:
            begin
               // Software starts polling only after its command write.
               if (start_poll || start_win)
               begin
                  busy_ff <= 1'b1;
                  done_ff <= 1'b0;
                  fail_ff <= 1'b0;
                  susp_ff <= 1'b0; // A stale suspend verdict must not outlive its poll.
                  pins_ff.addr <= addr_ff;
                  pins_ff.ce_n <= 1'b0;
                  pins_ff.oe_n <= 1'b0;
                  cnt_ff <= 4'(FSP_RD_CYC + 3);
                  state_ff <= start_win ? FSP_RDWIN : FSP_RD1;
               end
            end
            FSP_RD1, FSP_RD2, FSP_RD3, FSP_RDWIN:
            begin
               if (cnt_ff != 4'h0)
               begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
               else
               begin
                  // Strobe rises per read so the device counts a new cycle.
                  pins_ff.ce_n <= 1'b1;
                  pins_ff.oe_n <= 1'b1;
                  cnt_ff <= 4'(FSP_GAP_CYC);
                  state_ff <= FSP_GAP;
                  case (state_ff)
                     FSP_RD1:
                     begin
                        first_ff <= dq_s3_ff;
                        ret_ff <= FSP_RD2;
                     end
                     FSP_RD2:
                     begin
                        last_ff <= dq_s3_ff;
                        ret_ff <= FSP_CHK;
                     end
                     FSP_RD3:
                     begin
                        last_ff <= dq_s3_ff;
                        ret_ff <= FSP_CHK3;
                     end
                     default:
                     begin
                        // Window flag: low still accepts sectors, high means started.
                        win_ff <= dq_s3_ff[FSP_DQ_WINDOW];
                        busy_ff <= 1'b0;
                        ret_ff <= FSP_IDLE;
                     end
                  endcase
               end
            end
            FSP_GAP:
            begin
               if (cnt_ff != 4'h0)
               begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
               else if (ret_ff == FSP_RD2)
               begin
                  pins_ff.ce_n <= 1'b0;
                  pins_ff.oe_n <= 1'b0;
                  cnt_ff <= 4'(FSP_RD_CYC + 3);
                  state_ff <= ret_ff;
               end
               else
               begin
                  state_ff <= ret_ff;
                  pins_ff.doe <= 1'b0; // Write data is released only once the bus is idle.
               end
            end
            FSP_CHK:
            begin
               // Two back-to-back reads decide whether toggling goes on.
               if (first_ff[FSP_DQ_ACT_TGL] == last_ff[FSP_DQ_ACT_TGL])
               begin
                  done_ff <= 1'b1;
                  busy_ff <= 1'b0;
                  // Stopped activity toggle with a toggling sector: suspended.
                  susp_ff <= erase_ff && (first_ff[FSP_DQ_ERASE_TGL] != last_ff[FSP_DQ_ERASE_TGL]);
                  state_ff <= FSP_IDLE;
               end
               else
               begin
                  // Fail flag seen: one more read decides; else a fresh pair.
                  first_ff <= last_ff;
                  pins_ff.ce_n <= 1'b0;
                  pins_ff.oe_n <= 1'b0;
                  cnt_ff <= 4'(FSP_RD_CYC + 3);
                  state_ff <= last_ff[FSP_DQ_LIMIT] ? FSP_RD3 : FSP_RD1;
               end
            end
            FSP_CHK3:
            begin
               if (first_ff[FSP_DQ_ACT_TGL] == last_ff[FSP_DQ_ACT_TGL])
               begin
                  done_ff <= 1'b1;
                  busy_ff <= 1'b0;
                  state_ff <= FSP_IDLE;
               end
               else
               begin
                  // Still toggling: failure, write the reset command.
                  fail_ff <= 1'b1;
                  pins_ff.dout <= FSP_RESET_CMD;
                  pins_ff.doe <= 1'b1;
                  pins_ff.ce_n <= 1'b0;
                  pins_ff.we_n <= 1'b0;
                  cnt_ff <= 4'(FSP_WR_CYC);
                  state_ff <= FSP_WRRST;
               end
            end
            FSP_WRRST:
            begin
               if (cnt_ff != 4'h0)
               begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
               else
               begin
                  pins_ff.ce_n <= 1'b1;
                  pins_ff.we_n <= 1'b1;
                  cnt_ff <= 4'(FSP_GAP_CYC);
                  ret_ff <= FSP_IDLE;
                  busy_ff <= 1'b0;
                  state_ff <= FSP_GAP;
               end
            end
            default:
            begin
               state_ff <= FSP_IDLE;
            end
         endcase
      end
   end

   // Flash pins come straight from flip-flops.
   assign flash_ce_n = pins_ff.ce_n;
   assign flash_oe_n = pins_ff.oe_n;
   assign flash_we_n = pins_ff.we_n;
   assign flash_addr = pins_ff.addr;
   assign flash_dq_out = pins_ff.dout;
   assign flash_dq_oe = pins_ff.doe;

endmodule

`default_nettype wire

// [tb/fsp_poller_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Flash pin ordering checks
// ----------------------------------------------------------------
module fsp_poller_chk
   import fsp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Flash pins
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [17:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // An abort write ends polling at once and may cut a strobe short on purpose.
   wire logic abort_req;
   assign abort_req = psel && penable && pwrite && paddr == FSP_CTRL_OFF
      && pwdata[FSP_CTRL_ABORT_BIT];
   // A poll start on the bus and the beginning of a flash read.
   sequence s_start;
      psel && penable && pwrite && paddr == FSP_CTRL_OFF && pwdata[0] && !pwdata[2];
   endsequence
   sequence s_read;
      $fell(flash_oe_n);
   endsequence
   // Polling always begins with a pair of separate reads.
   property p_two_reads; disable iff (!presetn || abort_req)
      s_start |-> ##[1:20] s_read ##[4:40] s_read; endproperty
   a_two_reads: assert property (p_two_reads)
      else $error("poll start not followed by two reads");
   property p_rd_len; disable iff (!presetn || abort_req)
      s_read |-> (!flash_oe_n && !flash_ce_n)[*3]; endproperty
   a_rd_len: assert property (p_rd_len)
      else $error("read strobe too short");
   property p_gap; $rose(flash_oe_n) |-> flash_oe_n[*3]; endproperty
   a_gap: assert property (p_gap)
      else $error("reads not separated");
   property p_addr_hold; !flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr); endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved during read");
   property p_ce_oe; !flash_oe_n |-> !flash_ce_n && flash_we_n; endproperty
   a_ce_oe: assert property (p_ce_oe)
      else $error("read without chip select");
   // The only write the poller makes is the reset command.
   property p_rst_cmd; $fell(flash_we_n) |-> flash_dq_oe && flash_dq_out == FSP_RESET_CMD; endproperty
   a_rst_cmd: assert property (p_rst_cmd)
      else $error("write is not the reset command");
   property p_we_len; disable iff (!presetn || abort_req)
      $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && flash_dq_oe)[*3]; endproperty
   a_we_len: assert property (p_we_len)
      else $error("reset write strobe too short");
   property p_no_drive; flash_dq_oe |-> flash_oe_n; endproperty
   a_no_drive: assert property (p_no_drive)
      else $error("data driven during read");
endmodule
bind fsp_poller fsp_poller_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// [tb/fsp_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Behavioural flash status model
// ----------------------------------------------------------------
module fsp_flash_model
   import fsp_pkg::*;
#(
   parameter logic [7:0] ARRAY_BYTE = 8'h15
)
(
   // Host strobes
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [17:0] addr,
   input wire logic [15:0] din,
   // Device outputs
   output logic [15:0] dq,
   output logic ready_busy_output
);
   // Scenario knobs; a count of 1000 or more means the algorithm never ends.
   int busy_cnt = 0;
   logic lim = 1'b0, erase = 1'b0, susp = 1'b0, win = 1'b0, got_rst = 1'b0;
   logic act = 1'b1, ers = 1'b1, poll, stat;
   logic [17:0] rd_addr = '0;
   logic [15:0] cur, last = '0;
   // Status replaces array data only while an algorithm runs or is suspended.
   assign stat = busy_cnt != 0 || susp;
   assign poll = (erase && !susp) ? 1'b0 : (susp | ~ARRAY_BYTE[7]);
   // The window knob is the sector-erase timer: low still takes sectors, high obeys only
   // suspend, and a chip erase never raises it.
   assign cur = stat ? {8'h00, poll, act, lim, 1'b0, win, ers, 2'b00} : {8'h00, ARRAY_BYTE};
   // A released bus shows the inverse of the last word, so stale data never passes.
   assign dq = (!ce_n && !oe_n) ? cur : ~last;
   assign ready_busy_output = !(busy_cnt != 0 && !susp);
   // Each finished read advances the toggle flags and the algorithm.
   always @(posedge oe_n)
   begin
      last = cur;
      rd_addr = addr;
      if (busy_cnt != 0 && !susp)
         act = ~act;
      if (erase && stat)
         ers = ~ers;
      if (busy_cnt != 0 && busy_cnt < 1000 && !susp)
         busy_cnt--;
   end
   // The reset command ends status output unless the device is suspended.
   always @(posedge we_n)
   begin
      if (din[7:0] == FSP_RESET_CMD[7:0])
      begin
         busy_cnt = 0;
         lim = 1'b0;
         got_rst = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb/fsp_poller_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench for the status poller
// ----------------------------------------------------------------
module fsp_poller_tb
   import fsp_pkg::*;
;
   typedef struct {int busy; int lim; int erase; int susp; int done; int fail;} fsp_row_t;
   fsp_row_t rows[$] = '{'{-1, 0, 0, 0, 1, 0}, '{-1, 0, 1, 0, 1, 0}, '{2, 1, 0, 0, 1, 0},
      '{1000, 1, 1, 0, 0, 1}, '{1000, 0, 1, 1, 1, 0}};
   fsp_row_t r;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   fsp_apb_req_t req = '0;
   logic [31:0] prdata, q;
   logic pready, pslverr, ce_n, oe_n, we_n, dq_oe, ready_busy_output, err;
   logic [17:0] faddr, pa;
   logic [15:0] dq_out, dq_in;
   int n_mismatch = 0, checks_done = 0, seed = 32'hfef4831a, e;
   // The clock runs at 40 MHz.
   always #12.5 pclk = ~pclk;
   fsp_poller dut_u (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
      .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in), .ready_busy_output(ready_busy_output));
   fsp_flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .din(dq_out),
      .dq(dq_in), .ready_busy_output(ready_busy_output));
   // Verdict and end of run.
   task automatic summarize();
      if (n_mismatch == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer; an edge passes first so the release never meets a new setup.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      q = prdata;
      err = pslverr;
      req <= '0;
      if (n >= 50)
      begin
         n_mismatch++;
         summarize();
      end
   endtask
   // Poll the status word until the sequencer is idle.
   task automatic wait_idle();
      int k;
      k = 0;
      q = 32'h1;
      while (q[FSP_ST_BUSY_BIT] !== 1'b0 && k < 300)
      begin
         apb(1'b0, FSP_STAT_OFF, '0);
         k++;
      end
      // The ready pin passes a synchroniser, so let it settle before status is judged.
      repeat (5) @(posedge pclk);
      if (k >= 300)
      begin
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic start(input int busy, input logic [31:0] ctrl);
      flash_u.busy_cnt = busy;
      flash_u.act = 1'b1;
      flash_u.got_rst = 1'b0;
      apb(1'b1, FSP_CTRL_OFF, ctrl);
   endtask
   // Main sequence: reset, poll table, window reads, abort and restart.
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, FSP_STAT_OFF, '0);
      check("reset status", q, 32'h20);
      apb(1'b0, 12'h010, '0);
      check("slave error", {31'h0, err}, 32'h1);
      foreach (rows[i])
      begin
         r = rows[i];
         if (r.busy < 0)
            r.busy = $unsigned($random(seed)) % 6;
         flash_u.lim = r.lim[0];
         flash_u.erase = r.erase[0];
         flash_u.susp = r.susp[0];
         pa = 18'($random(seed));
         apb(1'b1, FSP_ADDR_OFF, {14'h0, pa});
         start(r.busy, 32'(r.erase << FSP_CTRL_ERASE_BIT) | 32'h1);
         wait_idle();
         apb(1'b0, FSP_STAT_OFF, '0);
         e = (r.done << FSP_ST_DONE_BIT) | (r.fail << FSP_ST_FAIL_BIT);
         e = e | (r.susp << FSP_ST_SUSP_BIT) | (1 << FSP_ST_RDY_BIT);
         check("status", q & 32'h3F, 32'(e));
         check("reset sent", {31'h0, flash_u.got_rst}, 32'(r.fail));
         check("poll address", {14'h0, flash_u.rd_addr}, {14'h0, pa});
         apb(1'b0, FSP_DATA_OFF, '0);
         if (r.lim == 0 && r.susp == 0)
            check("data", {16'h0, q[15:0]}, 32'h1515);
         flash_u.susp = 1'b0;
      end
      for (int w = 0; w < 2; w++)
      begin
         flash_u.win = w[0];
         start(1000, 32'h0A);
         wait_idle();
         apb(1'b0, FSP_STAT_OFF, '0);
         check("window", q & 32'h18, 32'(w << FSP_ST_WIN_BIT));
         apb(1'b0, FSP_CTRL_OFF, '0);
         check("erase kind", q, 32'h8);
      end
      flash_u.erase = 1'b0;
      start(1000, 32'h1);
      repeat (20) @(posedge pclk);
      apb(1'b0, FSP_STAT_OFF, '0);
      check("busy status", q & 32'h21, 32'h01);
      apb(1'b1, FSP_ADDR_OFF, {14'h0, ~pa});
      check("address kept", {14'h0, faddr}, {14'h0, pa});
      apb(1'b0, FSP_ADDR_OFF, '0);
      check("address refused", q, {14'h0, pa});
      apb(1'b1, FSP_CTRL_OFF, 32'h4);
      repeat (20) @(posedge pclk);
      apb(1'b0, FSP_STAT_OFF, '0);
      check("aborted", q & 32'h1, 32'h0);
      start(2, 32'h1);
      wait_idle();
      apb(1'b0, FSP_STAT_OFF, '0);
      check("restart", q & 32'h7, 32'h2);
      summarize();
   end
endmodule
`default_nettype wire
